// file: sim/adc_channel_result_config_asserts.sv
`timescale 1ns/1ps
module adc_channel_result_config_asserts (
    input wire clock_in,
    input wire nrst_in,
    input wire clk_en_in,
    input wire [15:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire word_in,
    input wire [15:0] rdata_out,
    input wire hit_out,
    input wire [7:0] port2_read_out,
    input wire [7:0] port8_direction_out,
    input wire neg_reference_select_out,
    input wire booster_enable_out,
    input wire [3:0] input_channel_select_out,
    input wire [11:0] analog_mask_out,
    input wire [11:0] pin_convert_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    // Accesses on an enabled clock, word writes included; a frozen clock takes none
    wire wr_t = wr_in && clk_en_in;
    wire rd_t = rd_in && clk_en_in;
    wire [7:0] p2_mask = {analog_mask_out[11], analog_mask_out[6:0]};
    property p_ref;
        wr_t && addr_in == 16'hFF2E |=> {neg_reference_select_out,
            booster_enable_out} == {$past(wdata_in[7]), $past(wdata_in[1])};
    endproperty
    a_ref: assert property (p_ref) else $error("ref ctrl bits");
    property p_chan;
        wr_t && addr_in == 16'hFF39 |=>
            input_channel_select_out == $past(wdata_in[3:0]);
    endproperty
    a_chan: assert property (p_chan) else $error("channel code");
    property p_cfg5;
        wr_t && addr_in == 16'hFF2F && wdata_in[4:0] == 5'h05 |=>
            analog_mask_out == 12'hFE0;
    endproperty
    a_cfg5: assert property (p_cfg5) else $error("pin cfg mask");
    property p_word;
        rd_t && word_in && addr_in == 16'hFF18 |=> rdata_out[15:12] == 4'h0;
    endproperty
    a_word: assert property (p_word) else $error("word top bits");
    property p_unmap;
        rd_t && !hit_out |=> rdata_out == 16'h0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_p8hi;
        port8_direction_out[7:4] == 4'hF;
    endproperty
    a_p8hi: assert property (p_p8hi) else $error("port8 high bits");
    property p_anlg;
        (port2_read_out & p2_mask) == 8'h00;
    endproperty
    a_anlg: assert property (p_anlg) else $error("analog pin read");
    property p_conv;
        $onehot0(pin_convert_out) && !(|(pin_convert_out & ~analog_mask_out));
    endproperty
    a_conv: assert property (p_conv) else $error("convert select");
    c_cfg: cover property (wr_t && addr_in == 16'hFF2F);
    c_word: cover property (rd_t && word_in);
    c_conv: cover property (|pin_convert_out);
endmodule // adc_channel_result_config_asserts

// file: sim/adc_channel_result_config_tb.sv
`timescale 1ns/1ps
module adc_channel_result_config_tb;
    reg clock_in = 1'b0;
    reg nrst_in = 1'b0;
    reg [15:0] addr = 16'h0000;
    reg [15:0] wdata = 16'h0000;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg word = 1'b0;
    reg start = 1'b0;
    reg [11:0] value = 12'h000;
    reg [7:0] p2_pins = 8'h00;
    reg clk_en = 1'b1;
    wire [3:0] p8_rd;
    wire fault;
    wire run, done, hit, nref, boost;
    wire [11:0] successive_approx_reg, mask, conv;
    wire [15:0] rdata;
    wire [7:0] p2_rd;
    integer fails = 0;
    integer check_count = 0;
    reg [15:0] rv;
    localparam bit [15:0] ra [6] = '{16'hFF19, 16'hFF22, 16'hFF28,
        16'hFF2E, 16'hFF2F, 16'hFF39};
    localparam bit [7:0] re [6] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h10, 8'h00};
    always #2.5 clock_in = ~clock_in;
    conv_core_model core (.clock_in(clock_in), .start_in(start),
        .value_in(value), .run_out(run), .done_out(done), .sar_out(successive_approx_reg));
    adc_channel_result_config uut (.clock_in(clock_in), .nrst_in(nrst_in),
        .clk_en_in(clk_en), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .word_in(word), .rdata_out(rdata), .hit_out(hit),
        .conversion_run_bit_in(run), .conv_done_in(done),
        .successive_approx_reg_in(successive_approx_reg), .amplifier_enable_bit_in(3'b000),
        .port2_pins_in(p2_pins), .port8_pins_in(4'hF),
        .port2_read_out(p2_rd), .port8_read_out(p8_rd),
        .port2_direction_out(),
        .port8_direction_out(), .neg_reference_select_out(nref),
        .booster_enable_out(boost), .input_channel_select_out(),
        .analog_mask_out(mask), .pin_convert_out(conv),
        .config_fault_out(fault), .write_while_running_out());
    task chk(input [8*8-1:0] what, input [15:0] exp, input [15:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED %0s exp %h got %h", what, exp, got);
            end
        end
    endtask
    // Strobes rise one negedge after entry, so calls never collide
    task cpu_wr(input [15:0] a, input [7:0] d);
        begin
            @(negedge clock_in);
            addr = a;
            wdata = {8'h00, d};
            wr = 1'b1;
            @(negedge clock_in) wr = 1'b0;
        end
    endtask
    task cpu_rd(input [15:0] a, input w);
        begin
            @(negedge clock_in);
            addr = a;
            word = w;
            rd = 1'b1;
            @(negedge clock_in) rd = 1'b0;
            rv = w ? rdata : {8'h00, rdata[7:0]};
        end
    endtask
    task t_reset;
        integer i;
        begin
            cpu_rd(16'hFF18, 1'b1);
            chk("word", 16'h0000, rv);
            for (i = 0; i < 6; i = i + 1) begin
                cpu_rd(ra[i], 1'b0);
                chk("reset", {8'h00, re[i]}, rv);
            end
            chk("mask", 16'h0000, {4'h0, mask});
        end
    endtask
    task t_result;
        begin
            value = 12'hABC;
            start = 1'b1;
            repeat (16) @(negedge clock_in);
            start = 1'b0;
            cpu_rd(16'hFF18, 1'b1);
            chk("word", 16'h0ABC, rv);
            cpu_rd(16'hFF18, 1'b0);
            chk("lobyte", 16'h00BC, rv);
            cpu_rd(16'hFF19, 1'b0);
            chk("hibyte", 16'h00AB, rv);
        end
    endtask
    task t_regs;
        begin
            cpu_wr(16'hFF2E, 8'hFF);
            cpu_rd(16'hFF2E, 1'b0);
            chk("refctl", 16'h0082, rv);
            chk("refout", 16'h0003, {14'h0000, nref, boost});
            cpu_wr(16'hFF39, 8'h07);
            cpu_rd(16'hFF39, 1'b0);
            chk("chan", 16'h0007, rv);
            // A frozen clock must not take a write
            clk_en = 1'b0;
            cpu_wr(16'hFF39, 8'h05);
            clk_en = 1'b1;
            cpu_rd(16'hFF39, 1'b0);
            chk("frozen", 16'h0007, rv);
            cpu_wr(16'hFF2F, 8'hE5);
            cpu_rd(16'hFF2F, 1'b0);
            chk("pincfg", 16'h0005, rv);
            chk("mask", 16'h0FE0, {4'h0, mask});
            cpu_wr(16'hFF2F, 8'h0F);
            chk("mask", 16'h0800, {4'h0, mask});
        end
    endtask
    task t_pins;
        begin
            cpu_wr(16'hFF2F, 8'h00);
            cpu_wr(16'hFF39, 8'h03);
            p2_pins = 8'hFF;
            repeat (3) @(negedge clock_in);
            chk("p2read", 16'h0000, {8'h00, p2_rd});
            chk("conv", 16'h0008, {4'h0, conv});
            chk("p8read", 16'h0000, {12'h000, p8_rd});
            chk("fault", 16'h0000, {15'h0000, fault});
            cpu_wr(16'hFF28, 8'h00);
            cpu_rd(16'hFF28, 1'b0);
            chk("p8dir", 16'h00F0, rv);
            cpu_wr(16'hFF2F, 8'h10);
            chk("p2read", 16'h00FF, {8'h00, p2_rd});
            chk("p8read", 16'h000F, {12'h000, p8_rd});
            chk("fault", 16'h0001, {15'h0000, fault});
            cpu_rd(16'hFF00, 1'b1);
            chk("unmap", 16'h0000, rv);
        end
    endtask
    task summarize;
        begin
            $display("checks %0d fails %0d", check_count, fails);
            if (fails == 0 && check_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(negedge clock_in);
        nrst_in = 1'b1;
        t_reset;
        t_result;
        t_regs;
        t_pins;
        summarize;
    end
    // Whole run needs well under 200 cycles
    initial begin
        #20000;
        fails = fails + 1;
        summarize;
    end
endmodule // adc_channel_result_config_tb
bind adc_channel_result_config adc_channel_result_config_asserts chk_i (
    .clock_in(clock_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .word_in(word_in), .rdata_out(rdata_out), .hit_out(hit_out),
    .port2_read_out(port2_read_out),
    .port8_direction_out(port8_direction_out),
    .neg_reference_select_out(neg_reference_select_out),
    .booster_enable_out(booster_enable_out),
    .input_channel_select_out(input_channel_select_out),
    .analog_mask_out(analog_mask_out), .pin_convert_out(pin_convert_out));

// file: sim/conv_core_model.sv
`timescale 1ns/1ps
module conv_core_model (
    input wire clock_in,
    input wire start_in,
    input wire [11:0] value_in,
    output reg run_out,
    output reg done_out,
    output reg [11:0] sar_out
);
    // One conversion per start; the result is only valid with done
    initial begin
        run_out = 1'b0;
        done_out = 1'b0;
        sar_out = 12'h000;
    end
    always @(posedge start_in) begin
        @(negedge clock_in) run_out = 1'b1;
        repeat (12) @(negedge clock_in);
        done_out = 1'b1;
        sar_out = value_in;
        @(negedge clock_in) done_out = 1'b0;
        sar_out = ~value_in; // Scrambled so a late copy is caught
        run_out = 1'b0;
    end
endmodule // conv_core_model

// file: src/adc_channel_result_config.v
// Behaviour
// [R1] Software rewrites trigger config only when stopped
// [R2] Reference bit 7 picks negative reference source
// [R3] Reference bit 1 enables booster; others zero
// [R4] Software waits 10 us after booster enable
// [R5] Software waits 1 us before run bit
// [R6] Result word: upper four bits read zero
// [R7] Conversion end copies approximation register to result
// [R8] Low byte at FF18H, byte result (bits 11:4) at FF19H
// [R9] Result word read whole, resets to zero
// [R10] Byte result holds top eight bits
// [R11] Byte read of FF19H returns bits 11:4
// [R12] Mode/channel/pin writes may corrupt results
// [R13] Four-bit channel code selects analog input
// [R14] Software writes zeros to channel bits 7:4
// [R15] Pin config count sets digital pins in order
// [R16] Pin config resets 10H; bits 7:5 zero
// [R17] Pin config written by byte only
// [R18] Analog pins need direction bit set to input
// [R19] Direction resets FFH; unimplemented bits read one
// [R20] Analog pin port read returns zero
// [R21] Software never selects a digital pin
// [R22] Selected analog input pin converted; prohibited combos
// [R23] Mode bit 7 is the conversion run bit
// [R24] Both result registers load in same cycle
// [R25] Prohibited codes are stored as written
`timescale 1ns/1ps
`include "adc_regs_map.vh"
module adc_channel_result_config #(
    parameter PORT2_PINS = 8
) (
    input wire clock_in,
    input wire nrst_in,
    input wire clk_en_in,
    // CPU data bus
    input wire [15:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire word_in,
    output reg [15:0] rdata_out,
    output wire hit_out,
    // Converter core side
    input wire conversion_run_bit_in,
    input wire conv_done_in,
    input wire [11:0] successive_approx_reg_in,
    input wire [2:0] amplifier_enable_bit_in,
    // Port pins for the shared functions
    input wire [7:0] port2_pins_in,
    input wire [3:0] port8_pins_in,
    output wire [7:0] port2_read_out,
    output wire [3:0] port8_read_out,
    output wire [7:0] port2_direction_out,
    output wire [7:0] port8_direction_out,
    output wire neg_reference_select_out,
    output wire booster_enable_out,
    output wire [3:0] input_channel_select_out,
    output wire [11:0] analog_mask_out,
    output wire [11:0] pin_convert_out,
    output wire config_fault_out,
    output wire write_while_running_out
);
    reg [15:0] conversion_result_word_reg;
    reg [7:0] conversion_result_high_byte_reg;
    reg [7:0] port2_direction_reg;
    reg [3:0] port8_direction_reg;
    reg neg_ref_reg;
    reg booster_reg;
    reg [3:0] chan_reg;
    reg [4:0] pin_cfg_reg;
    reg [7:0] p2_meta_reg;
    reg [7:0] p2_sync_reg;
    reg [3:0] p8_meta_reg;
    reg [3:0] p8_sync_reg;
    reg run_reg;
    reg [11:0] chan_onehot;
    reg [15:0] rd_next;
    reg hit;
    wire [11:0] analog_mask;
    wire [11:0] dir_in_mask;
    wire [11:0] pin_sync;
    wire wr_byte;

    assign wr_byte = wr_in & ~word_in;

    // Count-to-mask decode kept apart so it can be reused by the pin mux
    pin_config_decode u_decode (
        .pin_cfg_in(pin_cfg_reg),
        .analog_mask_out(analog_mask)
    );

    // Register writes; result registers are read-only
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            port2_direction_reg <= `RST_PORT_DIR; // [R19]
            port8_direction_reg <= 4'hF; // [R19]
            neg_ref_reg <= 1'b0;
            booster_reg <= 1'b0;
            chan_reg <= 4'h0;
            pin_cfg_reg <= 5'h10; // [R16]
        end else if (clk_en_in && wr_byte) begin
            case (addr_in)
                `ADDR_PORT2_DIR: port2_direction_reg <= wdata_in[7:0];
                `ADDR_PORT8_DIR: port8_direction_reg <= wdata_in[3:0];
                `ADDR_REF_CTRL: begin
                    neg_ref_reg <= wdata_in[`BIT_NEG_REF]; // [R2]
                    booster_reg <= wdata_in[`BIT_BOOSTER]; // [R3]
                end
                // Upper bits dropped; prohibited codes kept as written
                `ADDR_CHAN_SEL: chan_reg <= wdata_in[3:0]; // [R13] [R25]
                `ADDR_PIN_CFG: pin_cfg_reg <= wdata_in[4:0]; // [R15] [R25]
                default: ;
            endcase
        end
    end

    // Both results load from one completed value in one cycle
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            conversion_result_word_reg <= `RST_RESULT_WORD; // [R9]
            conversion_result_high_byte_reg <= `RST_RESULT_BYTE; // [R10]
        end else if (clk_en_in && conv_done_in) begin
            conversion_result_word_reg <=
                {4'h0, successive_approx_reg_in}; // [R6] [R7] [R24]
            conversion_result_high_byte_reg <=
                successive_approx_reg_in[11:4]; // [R10] [R24]
        end
    end

    // Two-stage synchroniser for the pin levels
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            p2_meta_reg <= 8'h00;
            p2_sync_reg <= 8'h00;
            p8_meta_reg <= 4'h0;
            p8_sync_reg <= 4'h0;
            run_reg <= 1'b0;
        end else if (clk_en_in) begin
            p2_meta_reg <= port2_pins_in;
            p2_sync_reg <= p2_meta_reg;
            p8_meta_reg <= port8_pins_in;
            p8_sync_reg <= p8_meta_reg;
            run_reg <= conversion_run_bit_in; // [R23]
        end
    end

    // Shared pin order: 0..6 on port 2, 8..11 on port 8, 15 on port 2 bit 7
    assign pin_sync = {p2_sync_reg[7], p8_sync_reg, p2_sync_reg[6:0]};
    assign dir_in_mask = {port2_direction_reg[7], port8_direction_reg,
                          port2_direction_reg[6:0]};

    // Channel code to pin index; prohibited codes select nothing
    always @* begin
        chan_onehot = 12'h000;
        case (chan_reg)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6:
                chan_onehot[chan_reg[2:0]] = 1'b1; // [R13]
            4'h8: chan_onehot[7] = 1'b1;
            4'h9: chan_onehot[8] = 1'b1;
            4'hA: chan_onehot[9] = 1'b1;
            4'hB: chan_onehot[10] = 1'b1;
            4'hF: chan_onehot[11] = 1'b1;
            default: chan_onehot = 12'h000;
        endcase
    end

    // A pin converts only when analog, input and selected
    genvar g;
    generate
        for (g = 0; g < `NUM_PINS; g = g + 1) begin : g_pin
            assign pin_convert_out[g] = analog_mask[g] & dir_in_mask[g] &
                chan_onehot[g]; // [R22]
        end
    endgenerate

    // Amplifier pins are 1,4,9 (indices 1,4,8); digital + amp is illegal
    assign config_fault_out =
        (amplifier_enable_bit_in[0] & ~analog_mask[1]) |
        (amplifier_enable_bit_in[1] & ~analog_mask[4]) |
        (amplifier_enable_bit_in[2] & ~analog_mask[8]) |
        (|(chan_onehot & ~analog_mask)); // [R22] [R21]

    // Flags a mode-side hazard for software debug; the block does not block
    assign write_while_running_out = run_reg & wr_in &
        ((addr_in == `ADDR_CHAN_SEL) | (addr_in == `ADDR_PIN_CFG)); // [R12]

    // Analog-configured pins read back as zero
    assign port2_read_out = {p2_sync_reg[7] & ~analog_mask[11],
                             p2_sync_reg[6:0] & ~analog_mask[6:0]}; // [R20]
    assign port8_read_out = p8_sync_reg & ~analog_mask[10:7]; // [R20]

    // Read decode; byte at FF19H returns the 8-bit result
    always @* begin
        rd_next = 16'h0000;
        hit = 1'b1;
        case (addr_in)
            `ADDR_RESULT_LO:
                rd_next = word_in ? conversion_result_word_reg
                    : {8'h00, conversion_result_word_reg[7:0]}; // [R8] [R9]
            `ADDR_RESULT_HI:
                rd_next = {8'h00, conversion_result_high_byte_reg}; // [R11]
            `ADDR_PORT2_DIR: rd_next = {8'h00, port2_direction_reg};
            `ADDR_PORT8_DIR:
                rd_next = {8'h00, 4'hF, port8_direction_reg}; // [R19]
            `ADDR_REF_CTRL:
                rd_next = {8'h00, neg_ref_reg, 5'h00, booster_reg,
                           1'b0}; // [R3]
            `ADDR_PIN_CFG: rd_next = {8'h00, 3'h0, pin_cfg_reg}; // [R16]
            `ADDR_CHAN_SEL: rd_next = {8'h00, 4'h0, chan_reg};
            default: hit = 1'b0;
        endcase
    end

    // Read data registered, valid the cycle after rd_in
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= 16'h0000;
        end else if (clk_en_in && rd_in) begin
            rdata_out <= rd_next;
        end
    end

    assign hit_out = hit & (rd_in | wr_in);
    assign port2_direction_out = port2_direction_reg;
    assign port8_direction_out = {4'hF, port8_direction_reg};
    assign neg_reference_select_out = neg_ref_reg;
    assign booster_enable_out = booster_reg;
    assign input_channel_select_out = chan_reg;
    assign analog_mask_out = analog_mask;
endmodule // adc_channel_result_config

// file: src/adc_regs_map.vh
`ifndef ADC_REGS_MAP_VH
`define ADC_REGS_MAP_VH

// Byte addresses in the CPU data space
`define ADDR_RESULT_LO 16'hFF18
`define ADDR_RESULT_HI 16'hFF19
`define ADDR_PORT2_DIR 16'hFF22
`define ADDR_PORT8_DIR 16'hFF28
`define ADDR_REF_CTRL 16'hFF2E
`define ADDR_PIN_CFG 16'hFF2F
`define ADDR_CHAN_SEL 16'hFF39

// Reset values
`define RST_RESULT_WORD 16'h0000
`define RST_RESULT_BYTE 8'h00
`define RST_PORT_DIR 8'hFF
`define RST_REF_CTRL 8'h00
`define RST_PIN_CFG 8'h10
`define RST_CHAN_SEL 8'h00

// Field positions and widths
`define BIT_NEG_REF 7
`define BIT_BOOSTER 1
`define PIN_CFG_W 5
`define CHAN_W 4
`define PORT8_IMPL_W 4

// Number of shared analog/digital pins
`define NUM_PINS 12

`endif

// file: src/pin_config_decode.v
`timescale 1ns/1ps
module pin_config_decode (
    input wire [4:0] pin_cfg_in,
    output reg [11:0] analog_mask_out
);
    localparam [4:0] NPINS = 5'h0C;
    reg [4:0] cnt;
    integer i;

    // Map the configuration code to a count of digital pins; the list of
    // pins is ordered 0..6, 8..11, 15 so the count maps directly
    always @* begin
        cnt = 5'h00;
        case (pin_cfg_in)
            5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06:
                cnt = pin_cfg_in;
            5'h08, 5'h09, 5'h0A, 5'h0B:
                cnt = pin_cfg_in - 5'h01;
            5'h0F: cnt = 5'h0B;
            5'h10: cnt = NPINS;
            default: cnt = 5'h00; // Prohibited codes: count 0, all pins analog
        endcase
        analog_mask_out = 12'h000;
        for (i = 0; i < 12; i = i + 1) begin
            analog_mask_out[i] = (i >= cnt); // [R15]
        end
    end
endmodule // pin_config_decode
